// *** hw/sfr_pkg.sv ***
// constants and types for the serial flash read command sequencer
`default_nettype none
package sfr_pkg;
   // command codes
   localparam logic [7:0] OP_RD_STATUS = 8'h05;
   localparam logic [7:0] OP_RD_FLAG = 8'h70;
   localparam logic [7:0] OP_RD_NVCFG = 8'hB5;
   localparam logic [7:0] OP_RD_VCFG = 8'h85;
   localparam logic [7:0] OP_RD_EXT = 8'hC8;
   localparam logic [7:0] OP_READ3 = 8'h03;
   localparam logic [7:0] OP_READ4 = 8'h13;
   localparam logic [7:0] OP_FAST3 = 8'h0B;
   localparam logic [7:0] OP_FAST4 = 8'h0C;
   localparam logic [7:0] OP_QOUT3 = 8'h6B;
   localparam logic [7:0] OP_QOUT4 = 8'h6C;
   localparam logic [7:0] OP_EN4B = 8'hB7;
   localparam logic [7:0] OP_DIS4B = 8'hE9;
   // field positions and reset values
   localparam int WRITE_BUSY_BIT = 0;
   localparam int ADDRESS_SIZE_BIT = 0;
   localparam logic [7:0] EXT_ADDR_RESET = 8'h00;
   localparam logic ADS_RESET = 1'b0;
   localparam logic [7:0] NO_DATA_BYTE = 8'hFF;
   // bit and clock counts
   localparam logic [5:0] OPCODE_BITS = 6'h08;
   localparam logic [5:0] ADDR3_BITS = 6'h18;
   localparam logic [5:0] ADDR4_BITS = 6'h20;
   localparam logic [5:0] REG_DUMMY_CLKS = 6'h08;
   localparam logic [5:0] CFG_DUMMY_BITS = 6'h08;
   localparam logic [5:0] FAST_DUMMY_CLKS = 6'h08;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int FAST_CLK_LIMIT_MHZ = 104;
   // data buffer
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;

   typedef enum logic [2:0] {
      ST_OPC = 3'b000,
      ST_ADDR = 3'b001,
      ST_DUMMY = 3'b010,
      ST_DATA = 3'b011,
      ST_IGNORE = 3'b100
   } sfr_state_e;

   typedef enum logic [2:0] {
      SRC_STATUS = 3'b000,
      SRC_FLAG = 3'b001,
      SRC_EXT = 3'b010,
      SRC_CFG = 3'b011,
      SRC_ARRAY = 3'b100
   } sfr_src_e;
endpackage
`default_nettype wire

// *** hw/sfr_fifo_if.sv ***
// carrier between the sequencer and its read data buffer
`timescale 1ns/1ps
`default_nettype none
interface sfr_fifo_if #(parameter int W = 8);
   logic push_valid;
   logic push_ready;
   logic [W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [W-1:0] pop_data;
   logic flush;
   modport user (output push_valid, push_data, pop_ready, flush,
                 input push_ready, pop_valid, pop_data);
   modport buf_side (input push_valid, push_data, pop_ready, flush,
                     output push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// *** hw/sfr_fifo.sv ***
// read data buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sfr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   sfr_fifo_if.buf_side f
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire do_push = f.push_valid & f.push_ready;
   wire do_pop = f.pop_valid & f.pop_ready;

   assign f.push_ready = (cnt_q != FULL_CNT);
   assign f.pop_valid = (cnt_q != '0);
   assign f.pop_data = mem_q[rd_q];

   always_ff @(posedge mclk_i) begin
      if (do_push) begin
         mem_q[wr_q] <= f.push_data;
      end
   end

   // a flush drops everything so a new command never sees stale bytes
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else if (f.flush) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (do_pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      end
   end

   a_fifo_bound: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      cnt_q <= FULL_CNT) else $error("buffer count past depth");
endmodule // sfr_fifo
`default_nettype wire

// *** hw/sfr_top.sv ***
// serial flash read command sequencer, device side
`timescale 1ns/1ps
`default_nettype none
module sfr_top (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic quad_line_0_i,
   input wire logic quad_line_1_i,
   input wire logic quad_line_2_i,
   input wire logic quad_line_3_i,
   output logic quad_line_0_o,
   output logic quad_line_1_o,
   output logic quad_line_2_o,
   output logic quad_line_3_o,
   output logic quad_line_0_oe_o,
   output logic quad_line_1_oe_o,
   output logic quad_line_2_oe_o,
   output logic quad_line_3_oe_o,
   input wire logic four_line_command_mode_i,
   input wire logic fast_clk_i,
   input wire logic write_busy_i,
   input wire logic [7:0] status_i,
   input wire logic [7:0] flag_i,
   input wire logic ext_addr_we_i,
   input wire logic [7:0] ext_addr_i,
   input wire logic [7:0] cfg_data_i,
   output logic [sfr_pkg::ADDR4_BITS-1:0] cfg_addr_o,
   output logic cfg_nv_o,
   output logic mem_req_o,
   output logic [sfr_pkg::ADDR4_BITS-1:0] mem_addr_o,
   input wire logic [sfr_pkg::FIFO_WIDTH-1:0] mem_rdata_i,
   input wire logic mem_rvalid_i,
   output logic address_size_o
);
   import sfr_pkg::*;

   // pins cross into mclk through two flops before any use
   logic [5:0] s1_q;
   logic [5:0] s2_q;
   logic sclk_d_q;
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s1_q <= 6'h20;
         s2_q <= 6'h20;
         sclk_d_q <= 1'b0;
      end else begin
         s1_q <= {cs_n_i, sclk_i, quad_line_3_i, quad_line_2_i,
                  quad_line_1_i, quad_line_0_i};
         s2_q <= s1_q;
         sclk_d_q <= s2_q[4];
      end
   end

   wire cs_hi = s2_q[5];
   wire [3:0] din = s2_q[3:0];
   wire rise = s2_q[4] & ~sclk_d_q & ~cs_hi;
   wire fall = ~s2_q[4] & sclk_d_q & ~cs_hi;
   wire four_line_command_mode = four_line_command_mode_i;

   sfr_state_e state_q;
   sfr_src_e src_q;
   logic [31:0] sh_q;
   logic [5:0] cnt_q;
   logic [5:0] dum_q;
   logic [5:0] alen_q;
   logic qout_q;
   logic ads_q;
   logic [7:0] ext_q;
   logic [31:0] cfg_addr_q;
   logic cfg_nv_q;

   // input shifting, one or four bits per rising edge
   wire [5:0] step = four_line_command_mode ? 6'h04 : 6'h01;
   wire [31:0] shift_in = four_line_command_mode ? {sh_q[27:0], din} : {sh_q[30:0], din[0]};
   wire [5:0] cnt_nx = cnt_q + step;
   wire [7:0] opc = shift_in[7:0];
   wire opc_done = (state_q == ST_OPC) && rise && (cnt_nx == OPCODE_BITS);
   wire addr_done = (state_q == ST_ADDR) && rise &&
                    (cnt_nx == OPCODE_BITS + alen_q);

   wire is_stat = (opc == OP_RD_STATUS);
   wire is_flag = (opc == OP_RD_FLAG);
   wire is_ext = (opc == OP_RD_EXT);
   wire is_reg = is_stat | is_flag | is_ext;
   wire is_cfg = (opc == OP_RD_NVCFG) | (opc == OP_RD_VCFG);
   wire is_norm = (opc == OP_READ3) | (opc == OP_READ4);
   wire is_fast = (opc == OP_FAST3) | (opc == OP_FAST4);
   wire is_qout = (opc == OP_QOUT3) | (opc == OP_QOUT4);
   wire is_4b_op = (opc == OP_READ4) | (opc == OP_FAST4) |
                   (opc == OP_QOUT4);

   // register reads: dummies only in four-line mode at high rates
   wire [5:0] reg_dummy = (four_line_command_mode && fast_clk_i) ? REG_DUMMY_CLKS : 6'h00;
   wire [5:0] cfg_dummy = four_line_command_mode ? (CFG_DUMMY_BITS >> 2) : CFG_DUMMY_BITS;
   wire [5:0] opc_dummy = is_reg ? reg_dummy :
                          is_cfg ? cfg_dummy :
                          (is_fast | is_qout) ? FAST_DUMMY_CLKS : 6'h00;
   wire [5:0] opc_alen = (is_4b_op | ads_q) ? ADDR4_BITS : ADDR3_BITS;
   wire busy_reject = (is_cfg | is_norm) & write_busy_i;
   wire sfr_state_e opc_state =
      is_reg ? ((reg_dummy != 6'h00) ? ST_DUMMY : ST_DATA) :
      busy_reject ? ST_IGNORE :
      (is_cfg | is_norm | is_fast | is_qout) ? ST_ADDR : ST_IGNORE;
   wire sfr_src_e opc_src = is_stat ? SRC_STATUS :
                            is_flag ? SRC_FLAG :
                            is_ext ? SRC_EXT :
                            is_cfg ? SRC_CFG : SRC_ARRAY;
   // 24-bit form: top byte from extended register
   wire [31:0] full_addr = (alen_q == ADDR4_BITS) ? shift_in :
                           {ext_q, shift_in[23:0]};

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= ST_OPC;
         cnt_q <= 6'h00;
      end else if (cs_hi) begin
         state_q <= ST_OPC;
         cnt_q <= 6'h00;
      end else if (rise) begin
         cnt_q <= cnt_nx;
         case (state_q)
            ST_OPC: begin
               if (opc_done) state_q <= opc_state;
            end
            ST_ADDR: begin
               if (addr_done) state_q <= (dum_q == 6'h00) ? ST_DATA : ST_DUMMY;
            end
            ST_DUMMY: begin
               if (dum_q == 6'h01) state_q <= ST_DATA;
            end
            default: state_q <= state_q;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sh_q <= 32'h0000_0000;
         src_q <= SRC_STATUS;
         dum_q <= 6'h00;
         alen_q <= ADDR3_BITS;
         qout_q <= 1'b0;
         cfg_nv_q <= 1'b0;
         cfg_addr_q <= 32'h0000_0000;
      end else if (rise) begin
         sh_q <= shift_in;
         if (opc_done) begin
            src_q <= opc_src;
            dum_q <= opc_dummy;
            alen_q <= opc_alen;
            qout_q <= is_qout;
            cfg_nv_q <= (opc == OP_RD_NVCFG);
         end
         if (addr_done) cfg_addr_q <= full_addr;
         if (state_q == ST_DUMMY) dum_q <= dum_q - 6'h01;
      end
   end

   // address size mode and extended register
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ads_q <= ADS_RESET;
         ext_q <= EXT_ADDR_RESET;
      end else begin
         if (opc_done && opc == OP_EN4B) ads_q <= 1'b1;
         if (opc_done && opc == OP_DIS4B) ads_q <= 1'b0;
         // cleared at reset, loaded by writer
         if (ext_addr_we_i) ext_q <= ext_addr_i;
      end
   end

   // array prefetch into the buffer
   sfr_fifo_if #(.W(FIFO_WIDTH)) fq ();
   logic fetch_on_q;
   logic pend_q;
   logic drop_q;
   logic [31:0] fetch_addr_q;
   logic req_q;
   logic [31:0] mem_addr_q;
   wire issue = fetch_on_q & ~pend_q & fq.push_ready;
   assign fq.push_valid = mem_rvalid_i & pend_q & ~drop_q & fetch_on_q;
   assign fq.push_data = mem_rdata_i;
   assign fq.flush = cs_hi;

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fetch_on_q <= 1'b0;
         pend_q <= 1'b0;
         drop_q <= 1'b0;
         fetch_addr_q <= 32'h0000_0000;
         req_q <= 1'b0;
         mem_addr_q <= 32'h0000_0000;
      end else begin
         req_q <= issue;
         if (cs_hi) fetch_on_q <= 1'b0;
         else if (addr_done && src_q == SRC_ARRAY) fetch_on_q <= 1'b1;
         // a late answer to an aborted command must not land in the buffer
         if (mem_rvalid_i) drop_q <= 1'b0;
         else if (cs_hi && pend_q) drop_q <= 1'b1;
         if (issue) pend_q <= 1'b1;
         else if (mem_rvalid_i) pend_q <= 1'b0;
         if (addr_done) fetch_addr_q <= full_addr;
         else if (issue) fetch_addr_q <= fetch_addr_q + 32'h0000_0001;
         if (issue) mem_addr_q <= fetch_addr_q;
      end
   end

   sfr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .f(fq.buf_side)
   );

   // live busy bit; an empty buffer shows all ones
   wire [7:0] status_byte = {status_i[7:1], write_busy_i};
   wire [7:0] flag_byte = {flag_i[7:1], ads_q};
   wire [7:0] byte_src = (src_q == SRC_STATUS) ? status_byte :
                         (src_q == SRC_FLAG) ? flag_byte :
                         (src_q == SRC_EXT) ? ext_q :
                         (src_q == SRC_CFG) ? cfg_data_i :
                         (fq.pop_valid ? fq.pop_data : NO_DATA_BYTE);
   logic [7:0] osh_q;
   logic [3:0] left_q;
   logic [3:0] qo_q;
   logic [3:0] oe_q;
   wire quad = four_line_command_mode | qout_q;
   wire [3:0] nbits = quad ? 4'h4 : 4'h1;
   wire data_fall = fall && (state_q == ST_DATA);
   // fresh byte each time, so polling sees live status
   wire [7:0] cur = (left_q == 4'h0) ? byte_src : osh_q;
   wire [3:0] left_nx = ((left_q == 4'h0) ? BYTE_BITS : left_q) - nbits;
   assign fq.pop_ready = data_fall && left_q == 4'h0 && src_q == SRC_ARRAY;

   // msb first, one or four lines per falling edge
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         osh_q <= 8'h00;
         left_q <= 4'h0;
         qo_q <= 4'h0;
         oe_q <= 4'h0;
      end else if (cs_hi) begin
         left_q <= 4'h0;
         oe_q <= 4'h0;
      end else if (data_fall) begin
         osh_q <= quad ? {cur[3:0], 4'h0} : {cur[6:0], 1'b0};
         left_q <= left_nx;
         qo_q <= quad ? cur[7:4] : {2'b00, cur[7], 1'b0};
         oe_q <= quad ? 4'hF : 4'h2;
      end
   end

   assign quad_line_0_o = qo_q[0];
   assign quad_line_1_o = qo_q[1];
   assign quad_line_2_o = qo_q[2];
   assign quad_line_3_o = qo_q[3];
   assign quad_line_0_oe_o = oe_q[0];
   assign quad_line_1_oe_o = oe_q[1];
   assign quad_line_2_oe_o = oe_q[2];
   assign quad_line_3_oe_o = oe_q[3];
   assign cfg_addr_o = cfg_addr_q;
   assign cfg_nv_o = cfg_nv_q;
   assign mem_req_o = req_q;
   assign mem_addr_o = mem_addr_q;
   assign address_size_o = ads_q;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);

   a_select_ends_cmd: assert property (
      cs_hi |=> state_q == ST_OPC && oe_q == 4'h0 ##1 oe_q == 4'h0)
      else $error("select high did not end the command");
   a_lines_released: assert property (
      oe_q != 4'h0 |-> state_q == ST_DATA && !$past(cs_hi))
      else $error("lines driven outside data phase");
   a_read_busy_reject: assert property (
      opc_done && is_norm && write_busy_i |=> state_q == ST_IGNORE)
      else $error("normal read accepted while busy");
   a_cfg_busy_reject: assert property (
      opc_done && is_cfg && write_busy_i |=> state_q == ST_IGNORE)
      else $error("config read accepted while busy");
   a_ads_enable: assert property (
      opc_done && opc == OP_EN4B |=> ads_q && address_size_o)
      else $error("address size bit not set");
   a_reg_dummy_count: assert property (
      opc_done && is_reg && four_line_command_mode && fast_clk_i |=>
      state_q == ST_DUMMY && dum_q == 6'h08)
      else $error("register read dummy count wrong");
   a_norm_no_dummy: assert property (
      addr_done && dum_q == 6'h00 |=> state_q == ST_DATA)
      else $error("normal read entered dummy phase");
   a_fetch_increment: assert property (
      issue && !addr_done |=> mem_req_o &&
      mem_addr_o == $past(fetch_addr_q) &&
      fetch_addr_q == $past(fetch_addr_q) + 32'h0000_0001)
      else $error("array address did not advance");
   a_ext_top_byte: assert property (
      addr_done && alen_q == ADDR3_BITS |=>
      cfg_addr_q[31:24] == $past(ext_q))
      else $error("extended byte not used in 24-bit form");
   a_wide_ignores_ext: assert property (
      addr_done && alen_q == ADDR4_BITS |=> cfg_addr_q == $past(shift_in))
      else $error("extended byte leaked into 32-bit address");
   a_status_msb_first: assert property (
      data_fall && left_q == 4'h0 && !quad && src_q == SRC_STATUS |=>
      quad_line_1_o == $past(status_byte[7]) && quad_line_1_oe_o)
      else $error("status msb not first on output line");
   a_busy_bit_live: assert property (
      data_fall && left_q == 4'h0 && src_q == SRC_STATUS && !quad |=>
      osh_q[1] == $past(write_busy_i)) else $error("busy bit missing");
endmodule // sfr_top
`default_nettype wire

// *** test/sfr_host.sv ***
// host controller model: drives select, serial clock and command bits
`timescale 1ns/1ps
`default_nettype none
module sfr_host (
   output logic cs_n_o,
   output logic sclk_o,
   output logic [3:0] dat_o,
   input wire logic [3:0] line_i
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      dat_o = 4'h0;
   end
   // clock stands low between frames
   task automatic pulse();
      #200 sclk_o = 1'b1;
      #200 sclk_o = 1'b0;
   endtask
   task automatic start();
      cs_n_o = 1'b0;
      #200;
   endtask
   task automatic send(input logic [31:0] v, input int n, input logic q);
      for (int i = 0; i < n; i += (q ? 4 : 1)) begin
         if (q) dat_o = v[31:28];
         else dat_o = {dat_o[3:1], v[31]};
         v = q ? v << 4 : v << 1;
         pulse();
      end
      // released lines must not keep the last value
      dat_o = ~dat_o;
   endtask
   task automatic dummy(input int n);
      repeat (n) pulse();
   endtask
   // quad data is one nibble per clock
   task automatic recv(input logic q, output logic [7:0] b);
      b = 8'h00;
      repeat (q ? 2 : 8) begin
         #200 sclk_o = 1'b1;
         // late sample: device output trails the fall by up to 3 mclk
         #100 b = q ? {b[3:0], line_i} : {b[6:0], line_i[1]};
         #100 sclk_o = 1'b0;
      end
   endtask
   task automatic stop();
      #200 cs_n_o = 1'b1;
      #500;
   endtask
endmodule // sfr_host
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the serial flash read command sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sfr_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic fl = 1'b0, fast = 1'b0, busy = 1'b0, ext_we = 1'b0, rv = 1'b0;
   logic [7:0] status = 8'h00, flag = 8'h00, ext = 8'h00;
   logic [7:0] cfg = 8'h00, rd = 8'h00;
   logic cs_n, sclk, nv, req, address_size_bit;
   wire [3:0] hdat, dout, doe, line;
   logic [31:0] cfg_addr, maddr;
   logic [31:0] req_q[$];
   int n_fail = 0, comparisons = 0, oe_cnt = 0;
   always #25 mclk = ~mclk;
   assign line = (doe & dout) | (~doe & hdat);
   sfr_host h (.cs_n_o(cs_n), .sclk_o(sclk), .dat_o(hdat), .line_i(line));
   sfr_top dut (.mclk_i(mclk), .reset_n_i(reset_n), .cs_n_i(cs_n),
      .sclk_i(sclk), .quad_line_0_i(line[0]), .quad_line_1_i(line[1]),
      .quad_line_2_i(line[2]), .quad_line_3_i(line[3]),
      .quad_line_0_o(dout[0]), .quad_line_1_o(dout[1]),
      .quad_line_2_o(dout[2]), .quad_line_3_o(dout[3]),
      .quad_line_0_oe_o(doe[0]), .quad_line_1_oe_o(doe[1]),
      .quad_line_2_oe_o(doe[2]), .quad_line_3_oe_o(doe[3]),
      .four_line_command_mode_i(fl), .fast_clk_i(fast),
      .write_busy_i(busy), .status_i(status), .flag_i(flag),
      .ext_addr_we_i(ext_we), .ext_addr_i(ext), .cfg_data_i(cfg),
      .cfg_addr_o(cfg_addr), .cfg_nv_o(nv), .mem_req_o(req),
      .mem_addr_o(maddr), .mem_rdata_i(rd), .mem_rvalid_i(rv),
      .address_size_o(address_size_bit));
   // memory answers each request one cycle later
   always @(posedge mclk) begin : mem_model
      logic r;
      logic [31:0] a;
      r = req;
      a = maddr;
      #2;
      rv = r;
      rd = a[7:0] + 8'h11;
      if (r) req_q.push_back(a);
   end
   always @(posedge mclk) if (|doe) oe_cnt++;
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic op(input logic [7:0] c);
      @(posedge mclk);
      #2 oe_cnt = 0;
      h.start();
      h.send({c, 24'h0}, 8, fl);
   endtask
   task automatic addr(input logic [31:0] a, input int n);
      h.send(a << (32 - n), n, fl);
   endtask
   task automatic fin();
      h.stop();
      chk("oe_after_select", 4'h0, doe);
   endtask
   task automatic get(input string nm, input logic [7:0] e, input logic q);
      logic [7:0] b;
      h.recv(q, b);
      chk(nm, e, b);
   endtask
   task automatic t_status();
      busy = 1'b1;
      status = 8'hA4;
      op(OP_RD_STATUS);
      chk("oe_cmd", 0, oe_cnt);
      get("status", 8'hA5, 1'b0);
      status = 8'hC2;
      busy = 1'b0;
      get("status_repeat", 8'hC2, 1'b0);
      fin();
   endtask
   task automatic t_flag();
      flag = 8'h80;
      for (int m = 0; m < 2; m++) begin
         op(m == 1 ? OP_DIS4B : OP_EN4B);
         fin();
         chk("address_size", m == 0, address_size_bit);
         op(OP_RD_FLAG);
         get("flag", {7'h40, m == 0}, 1'b0);
         get("flag_repeat", {7'h40, m == 0}, 1'b0);
         fin();
      end
   endtask
   task automatic t_ext();
      op(OP_RD_EXT);
      get("ext_reset", EXT_ADDR_RESET, 1'b0);
      fin();
      @(posedge mclk);
      #2 ext = 8'h5C;
      ext_we = 1'b1;
      @(posedge mclk);
      #2 ext_we = 1'b0;
      op(OP_RD_EXT);
      get("ext", 8'h5C, 1'b0);
      fin();
   endtask
   task automatic t_cfg();
      cfg = 8'h3C;
      for (int m = 0; m < 3; m++) begin
         busy = (m == 2);
         op(m == 1 ? OP_RD_VCFG : OP_RD_NVCFG);
         addr(32'h00123456, 24);
         h.dummy(8);
         chk("oe_cmd", 0, oe_cnt);
         if (m < 2) begin
            get("cfg", 8'h3C, 1'b0);
            chk("cfg_nv", m == 0, nv);
            chk("cfg_addr", 24'h123456, cfg_addr[23:0]);
         end else begin
            h.dummy(8);
            chk("oe_rejected", 0, oe_cnt);
         end
         fin();
      end
      busy = 1'b0;
   endtask
   task automatic t_read();
      for (int m = 0; m < 2; m++) begin
         busy = (m == 1);
         req_q.delete();
         op(OP_READ3);
         addr(32'h000000FE, 24);
         if (m == 0) begin
            for (int i = 0; i < 3; i++)
               get("array", 8'(8'hFE + i + 8'h11), 1'b0);
            chk("first_addr", 32'h5C0000FE, req_q[0]);
            chk("third_addr", 32'h5C000100, req_q[2]);
         end else begin
            h.dummy(16);
            chk("rejected_reqs", 0, req_q.size());
            chk("oe_rejected", 0, oe_cnt);
         end
         fin();
      end
      busy = 1'b0;
   endtask
   task automatic t_fast();
      logic [7:0] ops[6] = '{OP_READ4, OP_FAST3, OP_FAST4, OP_QOUT3,
                             OP_QOUT4, OP_FAST3};
      logic w;
      for (int m = 0; m < 6; m++) begin
         // last pass: four-byte mode widens a three-byte opcode
         w = (m % 2 == 0) || m == 5;
         if (m == 5) begin
            op(OP_EN4B);
            fin();
         end
         req_q.delete();
         op(ops[m]);
         addr(32'h01234567, w ? 32 : 24);
         if (m > 0) h.dummy(FAST_DUMMY_CLKS);
         chk("oe_cmd", 0, oe_cnt);
         for (int i = 0; i < 2; i++)
            get("burst", 8'(8'h78 + i), m == 3 || m == 4);
         chk("burst_addr", w ? 32'h01234567 : 32'h5C234567,
             req_q[0]);
         fin();
      end
      op(OP_DIS4B);
      fin();
   endtask
   task automatic t_qpi();
      fl = 1'b1;
      status = 8'h5A;
      for (int m = 0; m < 2; m++) begin
         fast = (m == 1);
         op(OP_RD_STATUS);
         if (m == 1) h.dummy(8);
         chk("oe_cmd", 0, oe_cnt);
         get("qpi_status", 8'h5A, 1'b1);
         fin();
      end
      fl = 1'b0;
      fast = 1'b0;
   endtask
   task automatic t_abort();
      op(OP_READ3);
      addr(32'h00000012, 8);
      fin();
      status = 8'h3E;
      op(OP_RD_STATUS);
      get("after_abort", 8'h3E, 1'b0);
      fin();
   endtask
   initial begin
      repeat (6) @(posedge mclk);
      #2 reset_n = 1'b1;
      repeat (4) @(posedge mclk);
      #2 chk("ads_reset", ADS_RESET, address_size_bit);
      t_status();
      t_flag();
      t_ext();
      t_cfg();
      t_read();
      t_fast();
      t_qpi();
      t_abort();
      tally_and_finish();
   end
   // 24 frames of under 30 us each
   initial begin
      #3000000;
      n_fail++;
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
